// ### pkg/aemc_pkg.sv
// constants and types of the axis enable and mode controller
package aemc_pkg;
	localparam int unsigned CLK_MHZ         = 125;
	localparam int unsigned RAMP_UNIT_US    = 1000;
	localparam int unsigned RAMP_UNIT_CYC   = RAMP_UNIT_US * CLK_MHZ;
	localparam int unsigned POS_W           = 12;
	localparam int unsigned BASIC_W         = 10;
	localparam int unsigned EXT_W           = 12;
	localparam int unsigned REDUCE_SHIFT    = 1;
	localparam int unsigned PROF_N          = 8;
	localparam int unsigned PROF_AW         = 3;
	localparam int unsigned SPEED_W         = 8;
	localparam int unsigned DWELL_W         = 16;
	localparam int unsigned CUR_W           = 11;
	localparam int unsigned INPOS_TOL       = 4;
	localparam int unsigned ENT_W           = POS_W + SPEED_W + DWELL_W + PROF_AW;
	localparam logic [1:0]  MODE_RESET      = 2'h0;

	typedef enum logic [1:0] {
		AEMC_MODE_LOCAL  = 2'h0,
		AEMC_MODE_SWREM  = 2'h1,
		AEMC_MODE_BUSREM = 2'h2
	} aemc_mode_t;

	typedef enum logic {
		AEMC_ST_DISABLED = 1'h0,
		AEMC_ST_ACTIVE   = 1'h1
	} aemc_state_t;

	// one stored profile: target, speed, dwell and chained successor (0 ends chain)
	typedef struct packed {
		logic [POS_W-1:0]   target;
		logic [SPEED_W-1:0] speed;
		logic [DWELL_W-1:0] dwell;
		logic [PROF_AW-1:0] next;
	} aemc_prof_t;

	// serial-side command pulses
	typedef struct packed {
		logic set_local;
		logic set_swrem;
		logic set_busrem;
		logic enable;
		logic disable_req;
	} aemc_cmd_t;
endpackage

// ### hw/aemc_prof_mem.sv
// profile store with registered read port, no reset and no reload of the image from nv backup
`timescale 1ns/100ps
module aemc_prof_mem (
	input  wire logic                          clk_i,
	input  wire logic                          we_i,
	input  wire logic [aemc_pkg::PROF_AW-1:0]  waddr_i,
	input  wire logic [aemc_pkg::ENT_W-1:0]    wdata_i,
	input  wire logic [aemc_pkg::PROF_AW-1:0]  raddr_i,
	output logic      [aemc_pkg::ENT_W-1:0]    rdata_o
);
	logic [aemc_pkg::ENT_W-1:0] mem [aemc_pkg::PROF_N];

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule

// ### hw/aemc_top.sv
// enable state machine, mode select, setpoint path and valve drive gating
// Functional notes
// - while disabled both solenoid current outputs are held at zero.
// - mode commands are taken only in the disabled state.
// - in the active state the stored mode is used and mode requests are refused.
// - enable comes from the enable input in local mode, or from the enable command (software mode) or bus_enable_i (fieldbus mode) with the enable input high.
// - disable comes from dropping the enable input in local mode or the disable command in software mode.
// - exactly three modes exist: local, remote software and remote fieldbus.
// - in remote software mode setpoint and profile come from the serial side, not the terminals.
// - the setpoint is either the mode's external source (analog input only in local mode) or a selected stored profile.
// - each profile has its own speed and dwell, and profiles chain into a sequence.
// - the in-position output rises when the position is within tolerance of the target and the ramped setpoint equals it.
// - an adjustable ramp time smooths the setpoint.
// - the closed loop can be switched off completely.
// - a save strobe to nonvolatile memory is passed out only while disabled; nothing is reloaded at power-up.
// - setpoint conversion width is 10 bits basic and 12 bits extended.
// - reduced input ranges give fewer effective bits than the converter width.
`timescale 1ns/100ps
module aemc_top (
	input  wire logic                          clk_i,
	input  wire logic                          rst_n_i,
	input  wire logic                          enable_pin_i,
	input  wire logic                          start_n_i,
	input  wire logic                          stop_n_i,
	input  wire logic                          ctrl_off_pin_i,
	input  wire logic                          ramp_off_pin_i,
	input  wire logic [2:0]                    prof_sel_pin_i,
	input  wire aemc_pkg::aemc_cmd_t           cmd_i,
	input  wire logic [2:0]                    sw_prof_sel_i,
	input  wire logic [aemc_pkg::POS_W-1:0]    sw_setpoint_i,
	input  wire logic                          bus_enable_i,
	input  wire logic [aemc_pkg::POS_W-1:0]    bus_setpoint_i,
	input  wire logic [aemc_pkg::POS_W-1:0]    adc_setpoint_i,
	input  wire logic [aemc_pkg::POS_W-1:0]    actual_pos_i,
	input  wire logic                          ext_variant_i,
	input  wire logic                          reduced_range_i,
	input  wire logic [1:0]                    ctrl_cfg_i,
	input  wire logic [7:0]                    ramp_time_i,
	input  wire logic                          prof_we_i,
	input  wire logic [aemc_pkg::PROF_AW-1:0]  prof_waddr_i,
	input  wire aemc_pkg::aemc_prof_t          prof_wdata_i,
	input  wire logic                          nv_save_i,
	output logic                               nv_save_o,
	output logic                               active_o,
	output aemc_pkg::aemc_mode_t               mode_o,
	output logic                               mode_refused_o,
	output logic                               in_pos_o,
	output logic                               loop_off_o,
	output logic [aemc_pkg::POS_W-1:0]         setpoint_o,
	output logic [aemc_pkg::CUR_W-1:0]         sol_a_o,
	output logic [aemc_pkg::CUR_W-1:0]         sol_b_o
);
	localparam int unsigned PW = aemc_pkg::POS_W;

	// pin synchronisers; stage one feeds only stage two
	logic [7:0] sync1_q;
	logic [7:0] sync2_q;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1_q <= 8'h03;
			sync2_q <= 8'h03;
		end else begin
			sync1_q <= {prof_sel_pin_i, ramp_off_pin_i, ctrl_off_pin_i, enable_pin_i, stop_n_i, start_n_i};
			sync2_q <= sync1_q;
		end
	end
	logic start_s, stop_s, en_s, coff_s, roff_s;
	logic [2:0] psel_s;
	assign start_s = ~sync2_q[0];
	assign stop_s  = ~sync2_q[1];
	assign en_s    = sync2_q[2];
	assign coff_s  = sync2_q[3];
	assign roff_s  = sync2_q[4];
	assign psel_s  = sync2_q[7:5];

	// state and mode
	aemc_pkg::aemc_state_t st_q, st_d;
	aemc_pkg::aemc_mode_t  mode_q, mode_d;
	logic                  refused_d;
	logic                  mode_req;
	assign mode_req = cmd_i.set_local | cmd_i.set_swrem | cmd_i.set_busrem;

	always_comb begin
		st_d      = st_q;
		mode_d    = mode_q;
		refused_d = 1'b0;
		unique case (st_q)
			aemc_pkg::AEMC_ST_DISABLED: begin
				// mode change only here, three modes
				if (cmd_i.set_local) begin
					mode_d = aemc_pkg::AEMC_MODE_LOCAL;
				end else if (cmd_i.set_swrem) begin
					mode_d = aemc_pkg::AEMC_MODE_SWREM;
				end else if (cmd_i.set_busrem) begin
					mode_d = aemc_pkg::AEMC_MODE_BUSREM;
				end
				// enable per mode, input active high
				if (!mode_req) begin
					unique case (mode_q)
						aemc_pkg::AEMC_MODE_LOCAL:  if (en_s) st_d = aemc_pkg::AEMC_ST_ACTIVE;
						aemc_pkg::AEMC_MODE_SWREM:  if (cmd_i.enable && en_s) st_d = aemc_pkg::AEMC_ST_ACTIVE;
						aemc_pkg::AEMC_MODE_BUSREM: if (bus_enable_i && en_s) st_d = aemc_pkg::AEMC_ST_ACTIVE;
						default: st_d = st_q;
					endcase
				end
			end
			aemc_pkg::AEMC_ST_ACTIVE: begin
				refused_d = mode_req;
				// disable per mode; losing the enable input always stops
				unique case (mode_q)
					aemc_pkg::AEMC_MODE_LOCAL:  if (!en_s) st_d = aemc_pkg::AEMC_ST_DISABLED;
					aemc_pkg::AEMC_MODE_SWREM:  if (cmd_i.disable_req || !en_s) st_d = aemc_pkg::AEMC_ST_DISABLED;
					aemc_pkg::AEMC_MODE_BUSREM: if (!bus_enable_i || !en_s) st_d = aemc_pkg::AEMC_ST_DISABLED;
					default: st_d = aemc_pkg::AEMC_ST_DISABLED;
				endcase
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q           <= aemc_pkg::AEMC_ST_DISABLED;
			mode_q         <= aemc_pkg::aemc_mode_t'(aemc_pkg::MODE_RESET);
			mode_refused_o <= 1'b0;
		end else begin
			st_q           <= st_d;
			mode_q         <= mode_d;
			mode_refused_o <= refused_d;
		end
	end
	assign active_o = (st_q == aemc_pkg::AEMC_ST_ACTIVE);
	assign mode_o   = mode_q;

	function automatic logic [PW-1:0] quantise(input logic [PW-1:0] v, input logic ext, input logic red);
		logic [PW-1:0] m;
		m = ext ? {PW{1'b1}} : {{aemc_pkg::BASIC_W{1'b1}}, {(PW-aemc_pkg::BASIC_W){1'b0}}};
		if (red) begin
			m = m << aemc_pkg::REDUCE_SHIFT;
		end
		return v & m;
	endfunction

	// source per mode; profile select with software, fieldbus or analog setpoint
	logic [2:0] psel;
	logic [PW-1:0] ext_sp;
	always_comb begin
		unique case (mode_q)
			aemc_pkg::AEMC_MODE_SWREM: begin
				psel   = sw_prof_sel_i;
				ext_sp = sw_setpoint_i;
			end
			aemc_pkg::AEMC_MODE_BUSREM: begin
				psel   = sw_prof_sel_i;
				ext_sp = bus_setpoint_i;
			end
			default: begin
				psel   = psel_s;
				ext_sp = quantise(adc_setpoint_i, ext_variant_i, reduced_range_i);
			end
		endcase
	end

	// profile sequencer: latch on start, dwell then follow chain
	logic [2:0]  prof_q, prof_d;
	logic [aemc_pkg::DWELL_W-1:0] dwell_q, dwell_d;
	logic [aemc_pkg::ENT_W-1:0] rd;
	aemc_pkg::aemc_prof_t ent;
	assign ent = rd;
	logic [PW-1:0] target;
	logic          at_pos;
	assign target = (prof_q == 3'h0) ? ext_sp : ent.target;

	// read at the next index so the registered word lines up with prof_q
	aemc_prof_mem i_aemc_prof_mem (
		.clk_i   (clk_i),
		.we_i    (prof_we_i),
		.waddr_i (prof_waddr_i),
		.wdata_i (prof_wdata_i),
		.raddr_i (prof_d),
		.rdata_o (rd)
	);

	always_comb begin
		prof_d  = prof_q;
		dwell_d = dwell_q;
		if (!active_o) begin
			prof_d  = 3'h0;
			dwell_d = '0;
		end else if (start_s && (psel != prof_q) && dwell_q == '0) begin
			prof_d = psel;
		end else if (prof_q != 3'h0 && at_pos) begin
			if (dwell_q == ent.dwell) begin
				dwell_d = '0;
				if (ent.next != 3'h0) begin
					prof_d = ent.next;
				end
			end else begin
				dwell_d = dwell_q + 1'b1;
			end
		end
	end

	// ramp: fixed tick period, one step every rlim+1 ticks, so the step interval scales with ramp time
	logic [$clog2(aemc_pkg::RAMP_UNIT_CYC+1)-1:0] pre_q, pre_d;
	logic [7:0]    rcnt_q, rcnt_d;
	logic [PW-1:0] sp_q, sp_d;
	logic          tick;
	logic [7:0]    rlim;
	assign tick = (pre_q == '0);
	// a profile brings its own speed; full speed 8'hFF steps straight to target
	assign rlim = (prof_q != 3'h0) ? ~ent.speed : ramp_time_i;
	always_comb begin
		pre_d  = tick ? ($bits(pre_q))'(aemc_pkg::RAMP_UNIT_CYC / (1 << PW)) : pre_q - 1'b1;
		rcnt_d = rcnt_q;
		sp_d   = sp_q;
		if (!active_o || stop_s) begin
			sp_d = active_o ? sp_q : actual_pos_i;
		end else if (rlim == 8'h00 || roff_s) begin
			sp_d = target;
		end else if (tick) begin
			if (rcnt_q >= rlim) begin
				rcnt_d = 8'h00;
				if (sp_q < target) begin
					sp_d = sp_q + 1'b1;
				end else if (sp_q > target) begin
					sp_d = sp_q - 1'b1;
				end
			end else begin
				rcnt_d = rcnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prof_q  <= 3'h0;
			dwell_q <= '0;
			pre_q   <= '0;
			rcnt_q  <= 8'h00;
			sp_q    <= '0;
		end else begin
			prof_q  <= prof_d;
			dwell_q <= dwell_d;
			pre_q   <= pre_d;
			rcnt_q  <= rcnt_d;
			sp_q    <= sp_d;
		end
	end

	// in position within tolerance of the final target
	assign at_pos = ((actual_pos_i > target) ? actual_pos_i - target : target - actual_pos_i) <= PW'(aemc_pkg::INPOS_TOL);

	// loop off: forced (2'h1) or external pin (2'h2); open loop maps setpoint to current
	logic loop_off;
	assign loop_off = (ctrl_cfg_i == 2'h1) || (ctrl_cfg_i == 2'h2 && coff_s);
	logic signed [PW:0] err;
	assign err = loop_off ? $signed({1'b0, sp_q}) - $signed({1'b0, 1'b1, {(PW-1){1'b0}}})
	                      : $signed({1'b0, sp_q}) - $signed({1'b0, actual_pos_i});

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			in_pos_o   <= 1'b0;
			loop_off_o <= 1'b0;
			setpoint_o <= '0;
			sol_a_o    <= '0;
			sol_b_o    <= '0;
			nv_save_o  <= 1'b0;
		end else begin
			in_pos_o   <= active_o && at_pos && (sp_q == target);
			loop_off_o <= loop_off;
			setpoint_o <= sp_q;
			// save allowed only while disabled, so a stable image is written
			nv_save_o  <= nv_save_i && !active_o;
			if (!active_d_ok(st_d) || stop_s) begin
				sol_a_o <= '0;
				sol_b_o <= '0;
			end else begin
				sol_a_o <= (err > 0) ? aemc_pkg::CUR_W'(err[PW-1:0]) : '0;
				sol_b_o <= (err < 0) ? aemc_pkg::CUR_W'(PW'(-err)) : '0;
			end
		end
	end

	function automatic logic active_d_ok(input aemc_pkg::aemc_state_t s);
		return s == aemc_pkg::AEMC_ST_ACTIVE;
	endfunction

	sol_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!active_o |-> (sol_a_o == '0 && sol_b_o == '0)) else $error("solenoid driven while disabled");
	mode_frozen_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		active_o && $past(active_o) |-> $stable(mode_o)) else $error("mode changed while active");
	refuse_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		active_o && mode_req |=> mode_refused_o) else $error("mode request not refused");
	mode_take_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!active_o && cmd_i.set_swrem && !cmd_i.set_local |=> mode_o == aemc_pkg::AEMC_MODE_SWREM && !active_o)
		else $error("mode command lost");
	local_en_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!active_o && mode_o == aemc_pkg::AEMC_MODE_LOCAL && en_s && !mode_req |=> active_o)
		else $error("local enable missed");
	no_en_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!en_s |=> !active_o) else $error("active without enable input");
	sw_dis_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		active_o && mode_o == aemc_pkg::AEMC_MODE_SWREM && cmd_i.disable_req |=> !active_o ##1 sol_a_o == '0)
		else $error("software disable ignored");
	mode_legal_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		mode_o != 2'h3) else $error("illegal mode");
	inpos_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		in_pos_o |-> $past(active_o)) else $error("in position while disabled");
	nv_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		nv_save_o |-> $past(nv_save_i) && !$past(active_o)) else $error("bad save strobe");
endmodule

// ### verif/aemc_host.sv
// host computer model: serial command pulses and the enable-control pin
`timescale 1ns/100ps
module aemc_host (
	input  wire logic           clk_i,
	output aemc_pkg::aemc_cmd_t cmd_o,
	output logic                enable_pin_o
);
	initial begin
		cmd_o = '0;
		enable_pin_o = 1'b0;
	end
	task automatic send(input aemc_pkg::aemc_cmd_t c);
		@(posedge clk_i);
		#1 cmd_o = c;
		@(posedge clk_i);
		#1 cmd_o = '0;
	endtask
	task automatic set_pin(input logic v);
		@(posedge clk_i);
		#1 enable_pin_o = v;
	endtask
endmodule

// ### verif/tb_aemc_top.sv
// self-checking bench of the axis enable and mode controller
`timescale 1ns/100ps
module tb_aemc_top;
	localparam aemc_pkg::aemc_cmd_t C_LOC = 5'h10;
	localparam aemc_pkg::aemc_cmd_t C_SW  = 5'h08;
	localparam aemc_pkg::aemc_cmd_t C_BUS = 5'h04;
	localparam aemc_pkg::aemc_cmd_t C_EN  = 5'h02;
	localparam aemc_pkg::aemc_cmd_t C_DIS = 5'h01;
	logic                 clk      = 1'b0;
	logic                 rst_n    = 1'b0;
	logic                 ctrl_off = 1'b0;
	logic                 ramp_off = 1'b1;
	logic [2:0]           prof_sel = 3'h0;
	logic [11:0]          sw_set   = 12'h0;
	logic                 bus_en   = 1'b0;
	logic [11:0]          adc      = 12'h0;
	logic [11:0]          actual   = 12'h0;
	logic                 ext      = 1'b1;
	logic                 reduced  = 1'b0;
	logic [1:0]           ctrl_cfg = 2'h0;
	logic [7:0]           ramp_t   = 8'h0;
	logic                 prof_we  = 1'b0;
	aemc_pkg::aemc_prof_t prof_wd  = '0;
	logic                 nv_save  = 1'b0;
	logic                 start_n  = 1'b0;
	logic                 stop_n   = 1'b1;
	logic [2:0]           sw_psel  = 3'h0;
	logic [11:0]          bus_sp   = 12'h0;
	logic [2:0]           prof_wa  = 3'h1;
	aemc_pkg::aemc_cmd_t  cmd;
	aemc_pkg::aemc_mode_t mode;
	logic                 en_pin, nv_done, active, refused, in_pos, loop_off;
	logic [11:0]          setpoint, cnt;
	logic [10:0]          sol_a, sol_b;
	int                   n_tests, miscompares;
	aemc_pkg::aemc_cmd_t  cmds[3] = '{C_SW, C_BUS, C_LOC};
	logic [11:0]          modes[3] = '{12'h1, 12'h2, 12'h0};

	always #4 clk = ~clk;

	aemc_host i_aemc_host (.clk_i(clk), .cmd_o(cmd), .enable_pin_o(en_pin));

	aemc_top i_aemc_top (
		.clk_i(clk), .rst_n_i(rst_n), .enable_pin_i(en_pin), .start_n_i(start_n), .stop_n_i(stop_n),
		.ctrl_off_pin_i(ctrl_off), .ramp_off_pin_i(ramp_off), .prof_sel_pin_i(prof_sel), .cmd_i(cmd),
		.sw_prof_sel_i(sw_psel), .sw_setpoint_i(sw_set), .bus_enable_i(bus_en), .bus_setpoint_i(bus_sp),
		.adc_setpoint_i(adc), .actual_pos_i(actual), .ext_variant_i(ext), .reduced_range_i(reduced),
		.ctrl_cfg_i(ctrl_cfg), .ramp_time_i(ramp_t), .prof_we_i(prof_we), .prof_waddr_i(prof_wa),
		.prof_wdata_i(prof_wd), .nv_save_i(nv_save), .nv_save_o(nv_done), .active_o(active), .mode_o(mode),
		.mode_refused_o(refused), .in_pos_o(in_pos), .loop_off_o(loop_off), .setpoint_o(setpoint),
		.sol_a_o(sol_a), .sol_b_o(sol_b)
	);

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic check(input string name, input logic [11:0] exp, input logic [11:0] got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	function automatic logic [11:0] probe(input int sel);
		case (sel)
			0: probe = {11'h0, active};
			1: probe = {11'h0, in_pos};
			2: probe = {11'h0, loop_off};
			default: probe = setpoint;
		endcase
	endfunction

	// bounded wait; running out ends the run
	task automatic wait_for(input string name, input int sel, input logic [11:0] exp, input int lim);
		int k;
		k = 0;
		while (probe(sel) !== exp && k < lim) begin
			tick(1);
			k++;
		end
		check(name, exp, probe(sel));
		if (probe(sel) !== exp) conclude();
	endtask

	task automatic sols();
		check("sol_a", 12'h0, {1'b0, sol_a});
		check("sol_b", 12'h0, {1'b0, sol_b});
	endtask

	initial begin
		n_tests = 0;
		miscompares = 0;
		tick(10);
		rst_n = 1'b1;
		check("active", 12'h0, {11'h0, active});
		check("mode", 12'h0, {10'h0, mode});
		sols();
		for (int i = 0; i < 3; i++) begin
			i_aemc_host.send(cmds[i]);
			check("mode", modes[i], {10'h0, mode});
		end
		prof_wd = '{target: 12'h400, speed: 8'hFF, dwell: 16'h0, next: 3'h0};
		prof_we = 1'b1;
		tick(1);
		// second profile dwells at its own target, then chains on to the first
		prof_wa = 3'h2;
		prof_wd = '{target: 12'h300, speed: 8'hFF, dwell: 16'h0020, next: 3'h1};
		tick(1);
		prof_we = 1'b0;
		nv_save = 1'b1;
		tick(1);
		nv_save = 1'b0;
		cnt = 12'h0;
		repeat (4) begin
			cnt = cnt + {11'h0, nv_done};
			tick(1);
		end
		check("nv_pulses", 12'h1, cnt);
		i_aemc_host.send(C_SW);
		sw_set = 12'h123;
		i_aemc_host.set_pin(1'b1);
		tick(3);
		i_aemc_host.send(C_EN);
		check("active", 12'h1, {11'h0, active});
		wait_for("sw_setpoint", 3, 12'h123, 50);
		i_aemc_host.send(C_LOC);
		check("refused", 12'h1, {11'h0, refused});
		check("mode", 12'h1, {10'h0, mode});
		prof_sel = 3'h1;
		tick(5);
		check("sw_ignores_pins", 12'h123, setpoint);
		sw_psel = 3'h1;
		wait_for("sw_profile", 3, 12'h400, 20);
		sw_psel = 3'h0;
		prof_sel = 3'h0;
		wait_for("sw_setpoint", 3, 12'h123, 20);
		ctrl_cfg = 2'h1;
		wait_for("loop_off", 2, 12'h1, 10);
		ctrl_cfg = 2'h2;
		wait_for("loop_on_pin", 2, 12'h0, 10);
		ctrl_off = 1'b1;
		wait_for("loop_off_pin", 2, 12'h1, 10);
		ctrl_off = 1'b0;
		ctrl_cfg = 2'h0;
		i_aemc_host.send(C_DIS);
		check("active", 12'h0, {11'h0, active});
		sols();
		i_aemc_host.set_pin(1'b0);
		tick(3);
		i_aemc_host.send(C_EN);
		check("active", 12'h0, {11'h0, active});
		i_aemc_host.send(C_LOC);
		adc = 12'h800;
		actual = 12'h800;
		i_aemc_host.set_pin(1'b1);
		wait_for("active", 0, 12'h1, 10);
		wait_for("analog", 3, 12'h800, 50);
		wait_for("in_pos", 1, 12'h1, 50);
		ext = 1'b0;
		adc = 12'hFFF;
		wait_for("basic_res", 3, 12'hFFC, 50);
		reduced = 1'b1;
		wait_for("reduced_res", 3, 12'hFF8, 50);
		ext = 1'b1;
		reduced = 1'b0;
		adc = 12'h800;
		wait_for("ext_res", 3, 12'h800, 50);
		// let the ramp-off pin settle first, else the step slips through unramped
		ramp_off = 1'b0;
		ramp_t = 8'h1;
		tick(3);
		adc = 12'h810;
		tick(20);
		check("ramp_slow", 12'h1, {11'h0, setpoint < 12'h804});
		wait_for("ramp_end", 3, 12'h810, 3000);
		ramp_off = 1'b1;
		prof_sel = 3'h1;
		wait_for("profile", 3, 12'h400, 50);
		actual = 12'h300;
		prof_sel = 3'h2;
		wait_for("chain_first", 3, 12'h300, 20);
		start_n = 1'b1;
		tick(5);
		check("dwell_hold", 12'h300, setpoint);
		wait_for("chain_next", 3, 12'h400, 100);
		check("sol_drive", 12'h1, {11'h0, sol_a != 11'h0});
		stop_n = 1'b0;
		tick(3);
		sols();
		check("stop_hold", 12'h400, setpoint);
		stop_n = 1'b1;
		start_n = 1'b0;
		prof_sel = 3'h0;
		i_aemc_host.set_pin(1'b0);
		wait_for("active", 0, 12'h0, 10);
		sols();
		i_aemc_host.send(C_BUS);
		bus_sp = 12'h234;
		bus_en = 1'b1;
		i_aemc_host.set_pin(1'b1);
		wait_for("bus_active", 0, 12'h1, 10);
		wait_for("bus_setpoint", 3, 12'h234, 20);
		bus_en = 1'b0;
		wait_for("bus_disable", 0, 12'h0, 5);
		sols();
		conclude();
	end
endmodule
